// ### logic/fct_timer.sv
/*
 Free-running 16-bit timer: prescaled or external counting, two compare
 channels with output pins, one capture channel, overflow, four interrupt
 request lines and an APB register port with a shared byte staging latch.
 Assumes software moves each 16-bit value as two byte accesses, upper
 byte first, and external pins may be asynchronous to pclk.
*/
`timescale 1ns/10ps
`default_nettype none

module fct_timer (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic [fct_pkg::ADDR_W-1:0] paddr,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [fct_pkg::DATA_W-1:0] pwdata,
	input  wire logic [3:0]                pstrb,
	output logic      [fct_pkg::DATA_W-1:0] prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      ext_count_clock_pin,
	input  wire logic                      capture_input_pin,
	output logic                           compare_a_pin,
	output logic                           compare_b_pin,
	output logic                           capture_irq,
	output logic                           compare_a_irq,
	output logic                           compare_b_irq,
	output logic                           overflow_irq
);

	fct_pkg::fct_state_t   q;
	fct_pkg::fct_state_t   d;
	fct_pkg::fct_apb_req_t req;
	fct_pkg::fct_apb_rsp_t rsp;
	fct_pkg::fct_irq_t     irq;
	logic                  ext_level;
	logic                  cap_level;

	function automatic logic is_mapped(input logic [fct_pkg::ADDR_W-1:0] a);
		case (a)
			fct_pkg::ADDR_COUNT_HI, fct_pkg::ADDR_COUNT_LO,
			fct_pkg::ADDR_CMPA_HI,  fct_pkg::ADDR_CMPA_LO,
			fct_pkg::ADDR_CMPB_HI,  fct_pkg::ADDR_CMPB_LO,
			fct_pkg::ADDR_CAP_HI,   fct_pkg::ADDR_CAP_LO,
			fct_pkg::ADDR_CTRL,     fct_pkg::ADDR_STAT: is_mapped = 1'b1;
			default:                                    is_mapped = 1'b0;
		endcase
	endfunction

	function automatic logic [15:0] join_bytes(input logic [7:0] hi, input logic [7:0] lo);
		join_bytes = {hi, lo};
	endfunction

	fct_pin_sync u_ext_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  (ext_count_clock_pin),
		.level   (ext_level)
	);

	fct_pin_sync u_cap_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  (capture_input_pin),
		.level   (cap_level)
	);

	always_comb begin
		req.paddr   = paddr;
		req.psel    = psel;
		req.penable = penable;
		req.pwrite  = pwrite;
		req.pwdata  = pwdata;
		req.pstrb   = pstrb;
	end

	// Access-phase strobes; a write or read takes effect at this edge only
	logic access;
	logic wr;
	logic rd;
	logic [7:0] wbyte;
	assign access = req.psel & req.penable;
	assign wr     = access & req.pwrite & req.pstrb[0] & is_mapped(req.paddr);
	assign rd     = access & ~req.pwrite & is_mapped(req.paddr);
	assign wbyte  = req.pwdata[7:0];

	logic wr_count_lo;
	logic wr_cmpa_lo;
	logic wr_cmpb_lo;
	logic rd_count_hi;
	logic rd_cap_hi;
	assign wr_count_lo = wr & (req.paddr == fct_pkg::ADDR_COUNT_LO);
	assign wr_cmpa_lo  = wr & (req.paddr == fct_pkg::ADDR_CMPA_LO);
	assign wr_cmpb_lo  = wr & (req.paddr == fct_pkg::ADDR_CMPB_LO);
	assign rd_count_hi = rd & (req.paddr == fct_pkg::ADDR_COUNT_HI);
	assign rd_cap_hi   = rd & (req.paddr == fct_pkg::ADDR_CAP_HI);

	// Count source level; external pin inverted so one falling-edge detector
	// serves all sources, and a source switch may itself count once
	fct_pkg::fct_cks_t cks;
	logic              src_level;
	assign cks = fct_pkg::fct_cks_t'(q.ctrl[fct_pkg::CTL_CKS_HI:fct_pkg::CTL_CKS_LO]);
	always_comb begin
		case (cks)
			fct_pkg::CKS_DIV2:  src_level = q.prescale[fct_pkg::TAP_DIV2];
			fct_pkg::CKS_DIV8:  src_level = q.prescale[fct_pkg::TAP_DIV8];
			fct_pkg::CKS_DIV32: src_level = q.prescale[fct_pkg::TAP_DIV32];
			fct_pkg::CKS_EXT:   src_level = ~ext_level;
			default:            src_level = 1'b0;
		endcase
	end

	logic count_pulse;
	assign count_pulse = q.src_prev & ~src_level;

	// Matches are inhibited during the lower-byte write to that value
	logic match_a;
	logic match_b;
	assign match_a = (q.count == q.cmpa) & ~wr_cmpa_lo;
	assign match_b = (q.count == q.cmpb) & ~wr_cmpb_lo;

	logic clear_a;
	assign clear_a = match_a & q.stat[fct_pkg::ST_CLR_A];

	logic cap_edge;
	logic cap_want;
	logic cap_strobe;
	assign cap_edge   = q.stat[fct_pkg::ST_EDGE] ? (cap_level & ~q.cap_prev)
	                                             : (~cap_level & q.cap_prev);
	assign cap_want   = cap_edge | q.cap_pending;
	assign cap_strobe = cap_want & ~rd_cap_hi;

	logic ovf_event;
	assign ovf_event = count_pulse & (q.count == fct_pkg::COUNT_MAX) & ~clear_a & ~wr_count_lo;

	always_comb begin
		d             = q;
		d.prescale    = q.prescale + 1'b1;
		d.src_prev    = src_level;
		d.cap_prev    = cap_level;
		d.cap_pending = cap_want & rd_cap_hi;

		// Counter: clear beats write, write beats increment
		if (clear_a) begin
			d.count = fct_pkg::COUNT_RST;
		end else if (wr_count_lo) begin
			d.count = join_bytes(q.latch, wbyte);
		end else if (count_pulse) begin
			d.count = q.count + 1'b1;
		end

		// Writes
		if (wr) begin
			case (req.paddr)
				fct_pkg::ADDR_COUNT_HI,
				fct_pkg::ADDR_CMPA_HI,
				fct_pkg::ADDR_CMPB_HI: begin
					d.latch = wbyte;
				end
				fct_pkg::ADDR_CMPA_LO: begin
					d.cmpa = join_bytes(q.latch, wbyte);
				end
				fct_pkg::ADDR_CMPB_LO: begin
					d.cmpb = join_bytes(q.latch, wbyte);
				end
				fct_pkg::ADDR_CTRL: begin
					d.ctrl = wbyte;
				end
				fct_pkg::ADDR_STAT: begin
					// Flags clear only if seen set by an earlier read
					d.stat = (q.stat & fct_pkg::ST_FLAG_MASK & ~({q.armed, 4'h0} & ~wbyte))
					       | (wbyte & fct_pkg::ST_CFG_MASK);
					d.armed = 4'h0;
				end
				default: begin
					d.latch = q.latch;
				end
			endcase
		end

		// Reads with side effects
		if (rd_count_hi) begin
			d.latch = q.count[7:0];
		end
		if (rd_cap_hi) begin
			d.latch = q.cap[7:0];
		end
		if (rd & (req.paddr == fct_pkg::ADDR_STAT)) begin
			d.armed = q.armed | q.stat[fct_pkg::ST_CAP_FLAG:fct_pkg::ST_OVF_FLAG];
		end

		if (cap_strobe) begin
			d.cap = q.count;
		end

		// Hardware sets come last so a set wins over a same-cycle clear
		if (cap_strobe) begin
			d.stat[fct_pkg::ST_CAP_FLAG] = 1'b1;
		end
		if (match_a) begin
			d.stat[fct_pkg::ST_CMPA_FLAG] = 1'b1;
		end
		if (match_b) begin
			d.stat[fct_pkg::ST_CMPB_FLAG] = 1'b1;
		end
		if (ovf_event) begin
			d.stat[fct_pkg::ST_OVF_FLAG] = 1'b1;
		end

		if (match_a & q.ctrl[fct_pkg::CTL_OEA]) begin
			d.pin_a = q.stat[fct_pkg::ST_LVLA];
		end
		if (match_b & q.ctrl[fct_pkg::CTL_OEB]) begin
			d.pin_b = q.stat[fct_pkg::ST_LVLB];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.count       <= fct_pkg::COUNT_RST;
			q.cmpa        <= fct_pkg::CMP_RST;
			q.cmpb        <= fct_pkg::CMP_RST;
			q.cap         <= fct_pkg::CAP_RST;
			q.latch       <= fct_pkg::BYTE_RST;
			q.ctrl        <= fct_pkg::BYTE_RST;
			q.stat        <= fct_pkg::BYTE_RST;
			q.armed       <= '0;
			q.prescale    <= '0;
			q.src_prev    <= 1'b0;
			q.cap_prev    <= 1'b0;
			q.cap_pending <= 1'b0;
			q.pin_a       <= 1'b0;
			q.pin_b       <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// Read data: compare values bypass the latch
	always_comb begin
		rsp.pready  = 1'b1;
		rsp.pslverr = access & ~is_mapped(req.paddr);
		rsp.prdata  = '0;
		if (access & ~req.pwrite) begin
			case (req.paddr)
				fct_pkg::ADDR_COUNT_HI: rsp.prdata[7:0] = q.count[15:8];
				fct_pkg::ADDR_COUNT_LO: rsp.prdata[7:0] = q.latch;
				fct_pkg::ADDR_CMPA_HI:  rsp.prdata[7:0] = q.cmpa[15:8];
				fct_pkg::ADDR_CMPA_LO:  rsp.prdata[7:0] = q.cmpa[7:0];
				fct_pkg::ADDR_CMPB_HI:  rsp.prdata[7:0] = q.cmpb[15:8];
				fct_pkg::ADDR_CMPB_LO:  rsp.prdata[7:0] = q.cmpb[7:0];
				fct_pkg::ADDR_CAP_HI:   rsp.prdata[7:0] = q.cap[15:8];
				fct_pkg::ADDR_CAP_LO:   rsp.prdata[7:0] = q.latch;
				fct_pkg::ADDR_CTRL:     rsp.prdata[7:0] = q.ctrl;
				fct_pkg::ADDR_STAT:     rsp.prdata[7:0] = q.stat;
				default:                rsp.prdata      = '0;
			endcase
		end
	end

	always_comb begin
		irq.capture   = q.stat[fct_pkg::ST_CAP_FLAG]  & q.ctrl[fct_pkg::CTL_CAP_IE];
		irq.compare_a = q.stat[fct_pkg::ST_CMPA_FLAG] & q.ctrl[fct_pkg::CTL_CMPA_IE];
		irq.compare_b = q.stat[fct_pkg::ST_CMPB_FLAG] & q.ctrl[fct_pkg::CTL_CMPB_IE];
		irq.overflow  = q.stat[fct_pkg::ST_OVF_FLAG]  & q.ctrl[fct_pkg::CTL_OVF_IE];
	end

	assign prdata        = rsp.prdata;
	assign pready        = rsp.pready;
	assign pslverr       = rsp.pslverr;
	assign compare_a_pin = q.pin_a;
	assign compare_b_pin = q.pin_b;
	assign capture_irq   = irq.capture;
	assign compare_a_irq = irq.compare_a;
	assign compare_b_irq = irq.compare_b;
	assign overflow_irq  = irq.overflow;

endmodule

`default_nettype wire

// ### common/fct_pkg.sv
/*
 Constants, register map and state types of the 16-bit free-running timer
 with two compare channels, one capture channel and overflow detection.
 Assumes an APB slave with 32-bit data; every byte register sits in the low
 byte of an aligned word.

//Contract
//- 16-bit values reached through one byte latch
//- Upper-byte write only loads the latch
//- Lower-byte write updates all 16 bits together
//- Upper-byte read also latches the lower byte
//- Lower-byte read returns the latch
//- Compare reads bypass the latch
//- Count once per selected source cycle
//- External source counts sampled rising edges
//- Compare match drives pin to level bit
//- Clear-on-match-A resets the counter
//- Capture edge chosen by edge select bit
//- Capture postponed by upper-byte capture read
//- Capture copies counter and sets flag
//- Overflow flag set on all-ones to zero
//- Four interrupt lines, each with enable
//- Clear beats counter lower-byte write
//- Counter lower-byte write beats increment
//- Compare lower-byte write suppresses that match
//- Count on falling edge of internal source
//- Source switch may add one increment
//- Select codes pick /2, /8, /32, external
//- Flags cleared by read-one then write-zero
//- Match when counter equals compare value
*/

package fct_pkg;

	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;

	// Byte addresses on the APB
	localparam logic [7:0]  ADDR_COUNT_HI = 8'h00;
	localparam logic [7:0]  ADDR_COUNT_LO = 8'h04;
	localparam logic [7:0]  ADDR_CMPA_HI  = 8'h08;
	localparam logic [7:0]  ADDR_CMPA_LO  = 8'h0C;
	localparam logic [7:0]  ADDR_CMPB_HI  = 8'h10;
	localparam logic [7:0]  ADDR_CMPB_LO  = 8'h14;
	localparam logic [7:0]  ADDR_CAP_HI   = 8'h18;
	localparam logic [7:0]  ADDR_CAP_LO   = 8'h1C;
	localparam logic [7:0]  ADDR_CTRL     = 8'h20;
	localparam logic [7:0]  ADDR_STAT     = 8'h24;

	// timer_control fields
	localparam int          CTL_CAP_IE    = 7;
	localparam int          CTL_CMPB_IE   = 6;
	localparam int          CTL_CMPA_IE   = 5;
	localparam int          CTL_OVF_IE    = 4;
	localparam int          CTL_OEB       = 3;
	localparam int          CTL_OEA       = 2;
	localparam int          CTL_CKS_HI    = 1;
	localparam int          CTL_CKS_LO    = 0;

	// timer_control_status fields
	localparam int          ST_CAP_FLAG   = 7;
	localparam int          ST_CMPB_FLAG  = 6;
	localparam int          ST_CMPA_FLAG  = 5;
	localparam int          ST_OVF_FLAG   = 4;
	localparam int          ST_LVLB       = 3;
	localparam int          ST_LVLA       = 2;
	localparam int          ST_EDGE       = 1;
	localparam int          ST_CLR_A      = 0;
	localparam logic [7:0]  ST_FLAG_MASK  = 8'hF0;
	localparam logic [7:0]  ST_CFG_MASK   = 8'h0F;

	localparam logic [15:0] COUNT_RST     = 16'h0000;
	localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
	localparam logic [15:0] CMP_RST       = 16'hFFFF;
	localparam logic [15:0] CAP_RST       = 16'h0000;
	localparam logic [7:0]  BYTE_RST      = 8'h00;

	// Prescaler taps: bit n toggles at pclk / 2^(n+1)
	localparam int          PRE_W         = 5;
	localparam int          TAP_DIV2      = 0;
	localparam int          TAP_DIV8      = 2;
	localparam int          TAP_DIV32     = 4;

	typedef enum logic [1:0] {
		CKS_DIV2  = 2'b00,
		CKS_DIV8  = 2'b01,
		CKS_DIV32 = 2'b10,
		CKS_EXT   = 2'b11
	} fct_cks_t;

	typedef struct packed {
		logic [ADDR_W-1:0] paddr;
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [DATA_W-1:0] pwdata;
		logic [3:0]        pstrb;
	} fct_apb_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic              pready;
		logic              pslverr;
	} fct_apb_rsp_t;

	typedef struct packed {
		logic capture;
		logic compare_a;
		logic compare_b;
		logic overflow;
	} fct_irq_t;

	typedef struct packed {
		logic ff1;
		logic ff2;
		logic ff3;
		logic level;
	} fct_sync_t;

	typedef struct packed {
		logic [15:0]      count;
		logic [15:0]      cmpa;
		logic [15:0]      cmpb;
		logic [15:0]      cap;
		logic [7:0]       latch;
		logic [7:0]       ctrl;
		logic [7:0]       stat;
		logic [3:0]       armed;
		logic [PRE_W-1:0] prescale;
		logic             src_prev;
		logic             cap_prev;
		logic             cap_pending;
		logic             pin_a;
		logic             pin_b;
	} fct_state_t;

endpackage

// ### logic/fct_pin_sync.sv
/*
 Three-stage input filter for a pin from outside the pclk domain.
 The level output changes only once the second and third stages agree.
*/
`timescale 1ns/10ps
`default_nettype none

module fct_pin_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin_in,
	output logic      level
);

	fct_pkg::fct_sync_t q;
	fct_pkg::fct_sync_t d;

	always_comb begin
		d       = q;
		d.ff1   = pin_in;
		d.ff2   = q.ff1;
		d.ff3   = q.ff2;
		// Only settled stages feed the level, never the first one
		if (q.ff2 == q.ff3) begin
			d.level = q.ff3;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level = q.level;

endmodule

`default_nettype wire

// ### test/fct_timer_properties.sv
/*
 Port-level checker for fct_timer: interrupt gating, compare pins, bus answers.
 Assumes it is bound to every fct_timer and sees only that module's ports.
*/
`timescale 1ns/10ps
`default_nettype none

module fct_timer_chk (
	input wire logic                       pclk,
	input wire logic                       presetn,
	input wire logic [fct_pkg::ADDR_W-1:0] paddr,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [fct_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0]                 pstrb,
	input wire logic [fct_pkg::DATA_W-1:0] prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	input wire logic                       ext_count_clock_pin,
	input wire logic                       capture_input_pin,
	input wire logic                       compare_a_pin,
	input wire logic                       compare_b_pin,
	input wire logic                       capture_irq,
	input wire logic                       compare_a_irq,
	input wire logic                       compare_b_irq,
	input wire logic                       overflow_irq
);
	logic [7:0] ctl_q;
	logic [7:0] cfg_q;
	logic       wr;

	// Shadow copies of the enables and levels, tracked from bus writes only
	assign wr = psel && penable && pwrite && pstrb[0];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= 8'h00;
			cfg_q <= 8'h00;
		end else if (wr && paddr == fct_pkg::ADDR_CTRL) begin
			ctl_q <= pwdata[7:0];
		end else if (wr && paddr == fct_pkg::ADDR_STAT) begin
			cfg_q <= pwdata[7:0] & fct_pkg::ST_CFG_MASK;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_CAP_IRQ: assert property (capture_irq |-> ctl_q[7])
		else $error("capture irq while disabled");
	AST_CMPA_IRQ: assert property (compare_a_irq |-> ctl_q[5])
		else $error("compare A irq while disabled");
	AST_CMPB_IRQ: assert property (compare_b_irq |-> ctl_q[6])
		else $error("compare B irq while disabled");
	AST_OVF_IRQ: assert property (overflow_irq |-> ctl_q[4])
		else $error("overflow irq while disabled");
	AST_PIN_A: assert property ($changed(compare_a_pin) |-> $past(ctl_q[2]) && compare_a_pin == $past(cfg_q[2]))
		else $error("pin A moved to wrong level");
	AST_PIN_B: assert property ($changed(compare_b_pin) |-> $past(ctl_q[3]) && compare_b_pin == $past(cfg_q[3]))
		else $error("pin B moved to wrong level");
	AST_BYTE_BUS: assert property (prdata[31:8] == 24'h000000)
		else $error("read data wider than a byte");
	AST_SLVERR: assert property (pslverr |-> psel && penable && (paddr[1:0] != 2'b00 || paddr > fct_pkg::ADDR_STAT))
		else $error("error answer on a mapped access");
	AST_SLVERR_MAP: assert property (psel && penable && (paddr[1:0] != 2'b00 || paddr > fct_pkg::ADDR_STAT) |-> pslverr)
		else $error("no error answer on an unmapped access");

	cover property ($rose(capture_irq));
	cover property ($rose(compare_b_pin));
	cover property ($rose(overflow_irq));
endmodule

bind fct_timer fct_timer_chk chk_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
	.pready, .pslverr, .ext_count_clock_pin, .capture_input_pin, .compare_a_pin, .compare_b_pin, .capture_irq,
	.compare_a_irq, .compare_b_irq, .overflow_irq);

`default_nettype wire

// ### test/fct_pin_model.sv
/*
 Pin-side partner: sends bursts of count clock pulses, follows a capture level.
 Assumes requests come as a one-cycle load strobe while not busy.
*/
`timescale 1ns/10ps
`default_nettype none

module fct_pin_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       ext_load,
	input  wire logic [3:0] ext_num,
	input  wire logic       cap_lvl,
	output logic            ext_pin,
	output logic            cap_pin,
	output logic            busy
);
	logic [3:0] left_q;
	logic [2:0] ph_q;

	assign busy = (left_q != 4'h0);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_q  <= 4'h0;
			ph_q    <= 3'h0;
			ext_pin <= 1'b0;
			cap_pin <= 1'b0;
		end else begin
			cap_pin <= cap_lvl;
			if (ext_load) begin
				left_q <= ext_num;
				ph_q   <= 3'h0;
			end else if (busy) begin
				ph_q    <= ph_q + 3'h1;
				// Four cycles high, four low: well over the minimum width
				ext_pin <= (ph_q < 3'h4);
				if (ph_q == 3'h7)
					left_q <= left_q - 4'h1;
			end
		end
	end
endmodule

`default_nettype wire

// ### test/tb.sv
/*
 Self-checking bench for fct_timer, driven as an APB master.
 Assumes the pin model supplies the count clock and capture pins.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic        pclk      = 1'b0;
	logic        presetn   = 1'b0;
	logic [7:0]  paddr     = 8'h00;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [31:0] pwdata    = 32'h00000000;
	logic        ext_load  = 1'b0;
	logic [3:0]  ext_num   = 4'h0;
	logic        cap_lvl   = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ext_pin;
	logic        cap_pin;
	logic        busy;
	logic        pin_a;
	logic        pin_b;
	logic        irq_c;
	logic        irq_a;
	logic        irq_b;
	logic        irq_o;
	logic        se;
	logic [31:0] r;
	logic [15:0] v;
	int          error_cnt = 0;
	int          compares  = 0;
	int          i;

	always #25 pclk = ~pclk;

	fct_timer dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_count_clock_pin(ext_pin), .capture_input_pin(cap_pin), .compare_a_pin(pin_a),
		.compare_b_pin(pin_b), .capture_irq(irq_c), .compare_a_irq(irq_a), .compare_b_irq(irq_b),
		.overflow_irq(irq_o));

	fct_pin_model pin_u (.pclk(pclk), .presetn(presetn), .ext_load(ext_load), .ext_num(ext_num),
		.cap_lvl(cap_lvl), .ext_pin(ext_pin), .cap_pin(cap_pin), .busy(busy));

	task automatic summarize();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
		int n;
		paddr  <= a;
		pwrite <= w;
		pwdata <= {24'h000000, d};
		psel   <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			summarize();
		end
		q  = prdata;
		se = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Upper byte first, as software must do
	task automatic rd16(input logic [7:0] a, output logic [15:0] d);
		xfer(a, 1'b0, 8'h00, r);
		d[15:8] = r[7:0];
		xfer(a + 8'h04, 1'b0, 8'h00, r);
		d[7:0] = r[7:0];
	endtask

	task automatic wr16(input logic [7:0] a, input logic [15:0] d);
		xfer(a, 1'b1, d[15:8], r);
		xfer(a + 8'h04, 1'b1, d[7:0], r);
	endtask

	// A flag clears only after it was read as set
	task automatic sclr(input logic [7:0] cfg);
		xfer(8'h24, 1'b0, 8'h00, r);
		xfer(8'h24, 1'b1, cfg, r);
	endtask

	task automatic pulses(input logic [3:0] n);
		int k;
		ext_num  <= n;
		ext_load <= 1'b1;
		@(posedge pclk);
		ext_load <= 1'b0;
		@(posedge pclk);
		for (k = 0; k < 200 && busy === 1'b1; k++)
			@(posedge pclk);
		if (k == 200) begin
			error_cnt++;
			summarize();
		end
		// Pin filter latency
		repeat (8) @(posedge pclk);
	endtask

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd16(8'h08, v);
		check(v, 16'hFFFF);
		rd16(8'h10, v);
		check(v, 16'hFFFF);
		rd16(8'h18, v);
		check(v, 16'h0000);
		xfer(8'h20, 1'b0, 8'h00, r);
		check(r[15:0], 16'h0000);
		xfer(8'h28, 1'b0, 8'h00, r);
		check(16'(se), 16'h0001);
		$display("test 1 done");
		wr16(8'h08, 16'h1234);
		rd16(8'h08, v);
		check(v, 16'h1234);
		xfer(8'h08, 1'b1, 8'hAB, r);
		rd16(8'h08, v);
		check(v, 16'h1234);
		xfer(8'h14, 1'b1, 8'h56, r);
		rd16(8'h10, v);
		check(v, 16'hAB56);
		$display("test 2 done");
		xfer(8'h20, 1'b1, 8'h03, r);
		wr16(8'h00, 16'hAA55);
		rd16(8'h00, v);
		check(v, 16'hAA55);
		xfer(8'h00, 1'b0, 8'h00, r);
		pulses(4'h3);
		xfer(8'h04, 1'b0, 8'h00, r);
		check(r[15:0], 16'h0055);
		rd16(8'h00, v);
		check(v, 16'hAA58);
		$display("test 3 done");
		for (i = 0; i < 3; i++) begin
			wr16(8'h00, 16'h0000);
			xfer(8'h20, 1'b1, 8'(i), r);
			repeat (128 << (2 * i)) @(posedge pclk);
			xfer(8'h20, 1'b1, 8'h03, r);
			rd16(8'h00, v);
			check(16'(v >= 16'h003F && v <= 16'h0044), 16'h0001);
		end
		$display("test 4 done");
		wr16(8'h00, 16'h0000);
		wr16(8'h08, 16'h0010);
		xfer(8'h24, 1'b1, 8'h05, r);
		xfer(8'h20, 1'b1, 8'h24, r);
		repeat (60) @(posedge pclk);
		check(16'({pin_a, irq_a}), 16'h0003);
		xfer(8'h20, 1'b1, 8'h27, r);
		rd16(8'h00, v);
		check(16'(v <= 16'h0010), 16'h0001);
		wr16(8'h08, 16'h8000);
		xfer(8'h24, 1'b1, 8'h05, r);
		check(16'(irq_a), 16'h0001);
		xfer(8'h24, 1'b0, 8'h00, r);
		check(r[15:0], 16'h0025);
		xfer(8'h24, 1'b1, 8'h05, r);
		xfer(8'h24, 1'b1, 8'hF5, r);
		check(16'(irq_a), 16'h0000);
		$display("test 5 done");
		wr16(8'h00, 16'hFFFE);
		wr16(8'h10, 16'hFFFF);
		xfer(8'h24, 1'b1, 8'h08, r);
		xfer(8'h20, 1'b1, 8'h5B, r);
		pulses(4'h1);
		check(16'({pin_b, irq_b, irq_o}), 16'h0006);
		pulses(4'h1);
		check(16'(irq_o), 16'h0001);
		rd16(8'h00, v);
		check(v, 16'h0000);
		$display("test 6 done");
		sclr(8'h00);
		xfer(8'h20, 1'b1, 8'h83, r);
		wr16(8'h00, 16'h1234);
		cap_lvl <= 1'b1;
		repeat (10) @(posedge pclk);
		check(16'(irq_c), 16'h0000);
		cap_lvl <= 1'b0;
		repeat (10) @(posedge pclk);
		check(16'(irq_c), 16'h0001);
		rd16(8'h18, v);
		check(v, 16'h1234);
		wr16(8'h00, 16'h4321);
		sclr(8'h02);
		check(16'(irq_c), 16'h0000);
		cap_lvl <= 1'b1;
		repeat (10) @(posedge pclk);
		rd16(8'h18, v);
		check(v, 16'h4321);
		$display("test 7 done");
		// Stopped counter held at compare A with clear on: every lower-byte write meets a clear
		wr16(8'h00, 16'h0000);
		wr16(8'h08, 16'h0000);
		xfer(8'h24, 1'b1, 8'h03, r);
		wr16(8'h00, 16'h1234);
		rd16(8'h00, v);
		check(v, 16'h0000);
		$display("test 8 done");
		summarize();
	end
endmodule

`default_nettype wire
